// ===== tcp_defines.vh
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TCP_ADDR_CTRL    4'h0
`define TCP_ADDR_COUNT   4'h1
`define TCP_ADDR_CMPA    4'h2
`define TCP_ADDR_CMPB    4'h3
`define TCP_ADDR_CAPTOP  4'h4
`define TCP_ADDR_FLAGS   4'h5
`define TCP_ADDR_PORT    4'h6
// ----------------------------------------
// control and flag field positions
// ----------------------------------------
`define TCP_CTRL_MODE_LO 0
`define TCP_CTRL_ACTA_LO 4
`define TCP_CTRL_ACTB_LO 6
`define TCP_CTRL_PRE_LO  8
`define TCP_FLAG_OVF     0
`define TCP_FLAG_CMPA    1
`define TCP_FLAG_CMPB    2
`define TCP_FLAG_CAP     3
// ----------------------------------------
// modes and fixed tops
// ----------------------------------------
`define TCP_MODE_CTC_A   4'h4
`define TCP_MODE_CTC_C   4'hC
`define TCP_MODE_FP8     4'h5
`define TCP_MODE_FP9     4'h6
`define TCP_MODE_FP10    4'h7
`define TCP_MODE_FP_C    4'hE
`define TCP_MODE_FP_A    4'hF
`define TCP_TOP8         16'h00FF
`define TCP_TOP9         16'h01FF
`define TCP_TOP10        16'h03FF
`define TCP_MAX          16'hFFFF
`define TCP_RESET_CTRL   10'h000
`endif

// ===== tcp_timer.v
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "tcp_defines.vh"
module tcp_timer (
   // clock and reset
   input  wire        ref_clk,
   input  wire        arst_n,
   input  wire        clk_en,
   // register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // pins
   output reg         wave_pin_a,
   output reg         wave_pin_a_oe,
   output reg         wave_pin_b,
   output reg         wave_pin_b_oe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [9:0]  ctrl_reg;
   reg [15:0] count_value_reg;
   reg [15:0] compare_a_value_reg;
   reg [15:0] compare_a_buf_reg;
   reg [15:0] compare_b_value_reg;
   reg [15:0] compare_b_buf_reg;
   reg [15:0] capture_top_value_reg;
   reg [3:0]  flags_reg;
   reg [3:0]  port_reg;
   reg        wave_out_a_reg;
   reg        wave_out_b_reg;
   reg        block_reg;
   reg [9:0]  pre_cnt_reg;

   wire [3:0] waveform_mode_sel = ctrl_reg[`TCP_CTRL_MODE_LO +: 4];
   wire [1:0] out_a_action      = ctrl_reg[`TCP_CTRL_ACTA_LO +: 2];
   wire [1:0] out_b_action      = ctrl_reg[`TCP_CTRL_ACTB_LO +: 2];
   wire [1:0] pre_sel           = ctrl_reg[`TCP_CTRL_PRE_LO +: 2];
   wire       pin_dir_out_a     = port_reg[0];
   wire       pin_dir_out_b     = port_reg[1];
   wire       port_val_a        = port_reg[2];
   wire       port_val_b        = port_reg[3];

   wire ctc_a = (waveform_mode_sel == `TCP_MODE_CTC_A);
   wire ctc_c = (waveform_mode_sel == `TCP_MODE_CTC_C);
   wire clear_on_match_mode = ctc_a | ctc_c;
   wire fp_a  = (waveform_mode_sel == `TCP_MODE_FP_A);
   wire fp_c  = (waveform_mode_sel == `TCP_MODE_FP_C);
   wire fp_fix = (waveform_mode_sel == `TCP_MODE_FP8) | (waveform_mode_sel == `TCP_MODE_FP9) |
                 (waveform_mode_sel == `TCP_MODE_FP10);
   wire fast_pwm = fp_fix | fp_a | fp_c;

   // ----------------------------------------
   // prescaler: factors 1, 8, 64, 1024 (no factor 256, select 3 gives 1024)
   // ----------------------------------------
   reg tick;
   always @* begin
      case (pre_sel)
         2'h0:    tick = 1'b1;
         2'h1:    tick = (pre_cnt_reg[2:0] == 3'h7);
         2'h2:    tick = (pre_cnt_reg[5:0] == 6'h3F);
         default: tick = (pre_cnt_reg[9:0] == 10'h3FF);
      endcase
   end
   // select 3 is factor 1024; factor 256 dropped to keep the select two bits wide

   // ----------------------------------------
   // top selection and masking
   // ----------------------------------------
   reg [15:0] top_val;
   always @* begin
      case (waveform_mode_sel)
         `TCP_MODE_FP8:  top_val = `TCP_TOP8;
         `TCP_MODE_FP9:  top_val = `TCP_TOP9;
         `TCP_MODE_FP10: top_val = `TCP_TOP10;
         `TCP_MODE_CTC_C,
         `TCP_MODE_FP_C: top_val = capture_top_value_reg;
         `TCP_MODE_CTC_A,
         `TCP_MODE_FP_A: top_val = compare_a_value_reg;
         default:        top_val = `TCP_MAX;
      endcase
   end
   wire [15:0] wr_mask = fp_fix ? top_val : `TCP_MAX;
   wire [15:0] wdata_m = reg_wdata & wr_mask;

   // unbuffered top: equality only, so a top below count is missed until wrap
   wire at_top   = (count_value_reg == top_val);
   wire at_max   = (count_value_reg == `TCP_MAX);
   wire match_a  = ~block_reg & (count_value_reg == compare_a_value_reg);
   wire match_b  = ~block_reg & (count_value_reg == compare_b_value_reg);
   wire clr_cnt  = (clear_on_match_mode & match_a & ctc_a) | (ctc_c & at_top & ~block_reg) |
                   (fast_pwm & at_top);
   wire [15:0] cnt_inc = count_value_reg + 16'h0001;

   // ----------------------------------------
   // output action per channel
   // ----------------------------------------
   function out_next;
      input       cur;
      input [1:0] act;
      input       match;
      input       top;
      input       fpm;
      input       chan_a;
      begin
         out_next = cur;
         if (act == 2'h1) begin
            if (match && (!fpm || chan_a))
               out_next = ~cur;
         end else if (act == 2'h2) begin
            if (fpm) begin
               if (match) out_next = 1'b0;
               else if (top) out_next = 1'b1;
            end else if (match) out_next = 1'b0;
         end else if (act == 2'h3) begin
            if (fpm) begin
               if (match) out_next = 1'b1;
               else if (top) out_next = 1'b0;
            end else if (match) out_next = 1'b1;
         end
      end
   endfunction

   // ----------------------------------------
   // registers and counter
   // ----------------------------------------
   wire wr_ctrl  = reg_wr & (reg_addr == `TCP_ADDR_CTRL);
   wire wr_cnt   = reg_wr & (reg_addr == `TCP_ADDR_COUNT);
   wire wr_cmpa  = reg_wr & (reg_addr == `TCP_ADDR_CMPA);
   wire wr_cmpb  = reg_wr & (reg_addr == `TCP_ADDR_CMPB);
   wire wr_cap   = reg_wr & (reg_addr == `TCP_ADDR_CAPTOP);
   wire wr_flags = reg_wr & (reg_addr == `TCP_ADDR_FLAGS);
   wire wr_port  = reg_wr & (reg_addr == `TCP_ADDR_PORT);

   reg [3:0] flag_set;
   always @* begin
      flag_set = 4'h0;
      if (tick) begin
         flag_set[`TCP_FLAG_OVF]  = fast_pwm ? at_top : at_max;
         flag_set[`TCP_FLAG_CMPA] = fp_a ? at_top : match_a;
         flag_set[`TCP_FLAG_CMPB] = match_b;
         flag_set[`TCP_FLAG_CAP]  = (ctc_c | fp_c) & at_top & (fp_c | ~block_reg);
      end
   end

   // ----------------------------------------
   // prescaler counter
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt_reg <= 10'h000;
      end else if (clk_en) begin
         // cleared at each tick, so a select change settles within one period
         pre_cnt_reg <= tick ? 10'h000 : pre_cnt_reg + 10'h001;
      end
   end

   // ----------------------------------------
   // control and port registers
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `TCP_RESET_CTRL;
         port_reg <= 4'h0;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[9:0];
         end
         if (wr_port) begin
            port_reg <= reg_wdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // capture top, never buffered
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         capture_top_value_reg <= 16'h0000;
      end else if (clk_en) begin
         if (wr_cap) begin
            capture_top_value_reg <= reg_wdata;
         end
      end
   end

   // ----------------------------------------
   // compare a, buffered in fast PWM only
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         compare_a_buf_reg   <= 16'h0000;
         compare_a_value_reg <= 16'h0000;
      end else if (clk_en) begin
         if (wr_cmpa) begin
            compare_a_buf_reg <= wdata_m;
         end
         // direct write elsewhere; load at top keeps a PWM period whole
         if (wr_cmpa && !fast_pwm) begin
            compare_a_value_reg <= wdata_m;
         end else if (fast_pwm && tick && at_top) begin
            compare_a_value_reg <= compare_a_buf_reg;
         end
      end
   end

   // ----------------------------------------
   // compare b, same buffering as a
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         compare_b_buf_reg   <= 16'h0000;
         compare_b_value_reg <= 16'h0000;
      end else if (clk_en) begin
         if (wr_cmpb) begin
            compare_b_buf_reg <= wdata_m;
         end
         if (wr_cmpb && !fast_pwm) begin
            compare_b_value_reg <= wdata_m;
         end else if (fast_pwm && tick && at_top) begin
            compare_b_value_reg <= compare_b_buf_reg;
         end
      end
   end

   // ----------------------------------------
   // counter and match blocking
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_value_reg <= 16'h0000;
         block_reg       <= 1'b0;
      end else if (clk_en) begin
         // block lasts until the next timer tick consumes it
         if (wr_cnt) begin
            block_reg <= 1'b1;
         end else if (tick) begin
            block_reg <= 1'b0;
         end
         if (wr_cnt) begin
            count_value_reg <= reg_wdata;
         end else if (tick) begin
            count_value_reg <= clr_cnt ? 16'h0000 : cnt_inc;
         end
      end
   end

   // ----------------------------------------
   // flags
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_reg <= 4'h0;
      end else if (clk_en) begin
         // set wins over a software clear, so no event is lost
         flags_reg <= (flags_reg & ~(wr_flags ? reg_wdata[3:0] : 4'h0)) | flag_set;
      end
   end

   // ----------------------------------------
   // internal wave state
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wave_out_a_reg <= 1'b0;
         wave_out_b_reg <= 1'b0;
      end else if (clk_en) begin
         if (tick) begin
            wave_out_a_reg <= out_next(wave_out_a_reg, out_a_action, match_a, at_top, fast_pwm, 1'b1);
            wave_out_b_reg <= out_next(wave_out_b_reg, out_b_action, match_b, at_top, fast_pwm, 1'b0);
         end
      end
   end

   // ----------------------------------------
   // read data, one cycle only
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en) begin
         reg_rdata <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               `TCP_ADDR_CTRL:   reg_rdata <= {6'h00, ctrl_reg};
               `TCP_ADDR_COUNT:  reg_rdata <= count_value_reg;
               `TCP_ADDR_CMPA:   reg_rdata <= fast_pwm ? compare_a_buf_reg : compare_a_value_reg;
               `TCP_ADDR_CMPB:   reg_rdata <= fast_pwm ? compare_b_buf_reg : compare_b_value_reg;
               `TCP_ADDR_CAPTOP: reg_rdata <= capture_top_value_reg;
               `TCP_ADDR_FLAGS:  reg_rdata <= {12'h000, flags_reg};
               `TCP_ADDR_PORT:   reg_rdata <= {12'h000, port_reg};
               default:          reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wave_pin_a    <= 1'b0;
         wave_pin_a_oe <= 1'b0;
         wave_pin_b    <= 1'b0;
         wave_pin_b_oe <= 1'b0;
      end else if (clk_en) begin
         // pin drive gated by direction; action 0 gives plain port value
         wave_pin_a    <= (out_a_action != 2'h0) ? wave_out_a_reg : port_val_a;
         wave_pin_a_oe <= pin_dir_out_a;
         wave_pin_b    <= (out_b_action != 2'h0) ? wave_out_b_reg : port_val_b;
         wave_pin_b_oe <= pin_dir_out_b;
      end
   end
endmodule

// ===== tcp_timer_monitor.sv
`timescale 1ns/1ps
`include "tcp_defines.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module tcp_timer_monitor (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        clk_en,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // pins
   input wire logic        wave_pin_a,
   input wire logic        wave_pin_a_oe,
   input wire logic        wave_pin_b,
   input wire logic        wave_pin_b_oe
);
   logic [3:0] mode_reg;
   wire        wr_take = reg_wr && clk_en;
   wire        rd_take = reg_rd && clk_en;
   wire        port_wr = wr_take && reg_addr == `TCP_ADDR_PORT;
   // mode shadow, only the masking check needs it
   always_ff @(posedge ref_clk or negedge arst_n)
      if (!arst_n)
         mode_reg <= 4'h0;
      else if (wr_take && reg_addr == `TCP_ADDR_CTRL)
         mode_reg <= reg_wdata[3:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_stall; !clk_en ##1 !clk_en; endsequence
   sequence s_mask_acc;
      wr_take && reg_addr == `TCP_ADDR_CMPA && mode_reg == `TCP_MODE_FP8 ##1 rd_take && reg_addr == `TCP_ADDR_CMPA;
   endsequence
   property p_rd_idle; !$past(rd_take) |-> reg_rdata == 16'h0000; endproperty
   property p_rd_spare; rd_take && reg_addr > `TCP_ADDR_PORT |=> reg_rdata == 16'h0000; endproperty
   property p_rd_dir; rd_take && reg_addr == `TCP_ADDR_PORT |=> reg_rdata[1:0] == {wave_pin_b_oe, wave_pin_a_oe};
   endproperty
   property p_oe_a; $changed(wave_pin_a_oe) |-> $past(port_wr) || $past(port_wr, 2); endproperty
   property p_oe_b; $changed(wave_pin_b_oe) |-> $past(port_wr) || $past(port_wr, 2); endproperty
   property p_hold_a; s_stall |=> $stable(wave_pin_a); endproperty
   property p_hold_b; s_stall |=> $stable(wave_pin_b); endproperty
   property p_mask; s_mask_acc |=> reg_rdata[15:8] == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_rd_spare: assert property (p_rd_spare) else $error("unmapped read not zero");
   a_rd_dir: assert property (p_rd_dir) else $error("enable differs from direction bits");
   a_oe_a: assert property (p_oe_a) else $error("pin a enable moved alone");
   a_oe_b: assert property (p_oe_b) else $error("pin b enable moved alone");
   a_hold_a: assert property (p_hold_a) else $error("pin a moved while stopped");
   a_hold_b: assert property (p_hold_b) else $error("pin b moved while stopped");
   a_mask: assert property (p_mask) else $error("compare not masked");
endmodule
bind tcp_timer tcp_timer_monitor u_mon (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
                                        .reg_rdata, .wave_pin_a, .wave_pin_a_oe, .wave_pin_b, .wave_pin_b_oe);

// ===== tcp_timer_tb.sv
`timescale 1ns/1ps
`include "tcp_defines.vh"
module tcp_timer_tb;
   // ----------------------------------------
   // stimulus and dut
   // ----------------------------------------
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire  [15:0] reg_rdata;
   wire         wave_pin_a, wave_pin_a_oe, wave_pin_b, wave_pin_b_oe;
   int          err_count = 0;
   int          checked = 0;
   int          cyc = 0;
   int          n;
   logic [15:0] pw_ctl [3] = '{16'h002E, 16'h003E, 16'h002E};
   logic [15:0] pw_cmp [3] = '{16'h0002, 16'h0002, 16'h0000};
   logic [15:0] pw_hi [3] = '{16'h0003, 16'h0005, 16'h0001};
   tcp_timer u_dut (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                    .wave_pin_a, .wave_pin_a_oe, .wave_pin_b, .wave_pin_b_oe);
   initial forever #20 ref_clk = ~ref_clk;
   // run is under a thousand cycles, a stuck wait ends here
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= r;
      @(posedge ref_clk);
   endtask
   // data stands one cycle only, so it is sampled mid-cycle
   task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      bus(a, 16'h0000, 1'b0, 1'b1);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(nm, reg_rdata & m, e);
      @(posedge ref_clk);
   endtask
   task automatic tick(input int c);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (c) @(posedge ref_clk);
   endtask
   // first pass syncs to an edge, second measures the gap
   task automatic per(input int lim, output int k);
      logic v;
      @(negedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         v = wave_pin_a;
         k = 0;
         while (wave_pin_a === v && k < lim) begin
            @(negedge ref_clk);
            k++;
         end
      end
      @(posedge ref_clk);
   endtask
   task automatic hi(output int k);
      k = 0;
      repeat (8) begin
         @(negedge ref_clk);
         if (wave_pin_a === 1'b1)
            k++;
      end
      @(posedge ref_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd("ctrl", `TCP_ADDR_CTRL, 16'hFFFF, 16'h0000);
      rd("port", `TCP_ADDR_PORT, 16'hFFFF, 16'h0000);
      bus(4'h9, 16'hBEEF, 1'b1, 1'b0);
      rd("spare", 4'h9, 16'hFFFF, 16'h0000);
      bus(`TCP_ADDR_CMPB, 16'h1234, 1'b1, 1'b0);
      rd("cmpb", `TCP_ADDR_CMPB, 16'hFFFF, 16'h1234);
      for (int i = 0; i < 2; i++) begin
         bus(`TCP_ADDR_CTRL, i ? 16'h000C : 16'h0004, 1'b1, 1'b0);
         bus(i ? `TCP_ADDR_CAPTOP : `TCP_ADDR_CMPA, 16'h0005, 1'b1, 1'b0);
         bus(`TCP_ADDR_COUNT, 16'h0000, 1'b1, 1'b0);
         bus(`TCP_ADDR_FLAGS, 16'h000F, 1'b1, 1'b0);
         tick(20);
         rd("top flag", `TCP_ADDR_FLAGS, 16'h0002 << 2 * i, 16'h0002 << 2 * i);
         rd("ctc count", `TCP_ADDR_COUNT, 16'hFFF8, 16'h0000);
      end
      bus(`TCP_ADDR_CTRL, 16'h0004, 1'b1, 1'b0);
      bus(`TCP_ADDR_CMPA, 16'hFFF0, 1'b1, 1'b0);
      bus(`TCP_ADDR_COUNT, 16'hFFF0, 1'b1, 1'b0);
      bus(`TCP_ADDR_FLAGS, 16'h000F, 1'b1, 1'b0);
      tick(40);
      rd("ovf only", `TCP_ADDR_FLAGS, 16'h0003, 16'h0001);
      rd("wrapped", `TCP_ADDR_COUNT, 16'hFF00, 16'h0000);
      bus(`TCP_ADDR_PORT, 16'h0001, 1'b1, 1'b0);
      for (int i = 0; i < 2; i++) begin
         bus(`TCP_ADDR_CTRL, 16'h0014 | (16'(i) << 8), 1'b1, 1'b0);
         bus(`TCP_ADDR_CMPA, 16'h0003, 1'b1, 1'b0);
         bus(`TCP_ADDR_COUNT, 16'h0000, 1'b1, 1'b0);
         tick(1);
         per(100, n);
         chk("half period", 16'(n), i ? 16'h0020 : 16'h0004);
      end
      clk_en <= 1'b0;
      per(40, n);
      chk("frozen", 16'(n), 16'h0028);
      clk_en <= 1'b1;
      bus(`TCP_ADDR_CTRL, 16'h0004, 1'b1, 1'b0);
      tick(1);
      per(40, n);
      chk("no action", 16'(n), 16'h0028);
      bus(`TCP_ADDR_PORT, 16'h0000, 1'b1, 1'b0);
      tick(3);
      chk("dir off", {15'h0000, wave_pin_a_oe}, 16'h0000);
      bus(`TCP_ADDR_PORT, 16'h0001, 1'b1, 1'b0);
      bus(`TCP_ADDR_CAPTOP, 16'h0007, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         bus(`TCP_ADDR_CTRL, pw_ctl[i], 1'b1, 1'b0);
         bus(`TCP_ADDR_CMPA, pw_cmp[i], 1'b1, 1'b0);
         bus(`TCP_ADDR_COUNT, 16'h0000, 1'b1, 1'b0);
         bus(`TCP_ADDR_FLAGS, 16'h000F, 1'b1, 1'b0);
         tick(20);
         hi(n);
         chk("high time", 16'(n), pw_hi[i]);
         rd("pwm flags", `TCP_ADDR_FLAGS, 16'h0009, 16'h0009);
      end
      bus(`TCP_ADDR_CTRL, 16'h0004, 1'b1, 1'b0);
      bus(`TCP_ADDR_CMPA, 16'h0007, 1'b1, 1'b0);
      bus(`TCP_ADDR_COUNT, 16'h0000, 1'b1, 1'b0);
      bus(`TCP_ADDR_CTRL, 16'h001F, 1'b1, 1'b0);
      tick(20);
      per(100, n);
      chk("pwm toggle", 16'(n), 16'h0008);
      bus(`TCP_ADDR_CMPA, 16'h0064, 1'b1, 1'b0);
      tick(10);
      bus(`TCP_ADDR_COUNT, 16'h0032, 1'b1, 1'b0);
      bus(`TCP_ADDR_CMPA, 16'h000A, 1'b1, 1'b0);
      tick(60);
      rd("buffered top", `TCP_ADDR_COUNT, 16'hFFF0, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         bus(`TCP_ADDR_CTRL, i ? 16'h0007 : 16'h0005, 1'b1, 1'b0);
         bus(`TCP_ADDR_CMPA, 16'hABCD, 1'b1, 1'b0);
         rd("masked cmp", `TCP_ADDR_CMPA, 16'hFFFF, i ? 16'h03CD : 16'h00CD);
      end
      stop_test();
   end
endmodule
